// ---- inc/cst_defs.svh ----
`ifndef CST_DEFS_SVH
`define CST_DEFS_SVH
// Register page and addresses on the special function register bus
`define CST_PAGE_MAIN        8'h00
`define CST_ADDR_CONFIG      8'hAA
`define CST_ADDR_CONTROL     8'hB0
`define CST_ADDR_SCAN_START  8'hDD
`define CST_ADDR_SCAN_END    8'hDE
`define CST_ADDR_THR_LOW     8'hD9
`define CST_ADDR_THR_HIGH    8'hDA
`define CST_ADDR_MUX_SEL     8'hAB
// Control register field positions
`define CST_CTL_ENABLE       7
`define CST_CTL_INT_FLAG     5
`define CST_CTL_BUSY         4
`define CST_CTL_GT_FLAG      0
// Config register fields
`define CST_CFG_MODE_HI      6
`define CST_CFG_MODE_LO      4
`define CST_CFG_WAKE_END     3
`define CST_CFG_ACC_HI       1
`define CST_CFG_ACC_LO       0
`define CST_CFG_WMASK        8'h7B
`define CST_MODE_TOUCH_STOP  3'h5
// Reset values
`define CST_RST_BYTE         8'h00
`define CST_RST_CHAN         5'h00
`define CST_RST_THR          16'h0000
`endif

// ---- inc/cst_pkg.sv ----
package cst_pkg;
  typedef enum logic {CST_IDLE, CST_CONV} cst_state_t;

  // Whole state of the top module
  typedef struct packed {
    cst_state_t  st;
    logic [7:0]  cfg;
    logic        en;
    logic        busy;
    logic        int_flag;
    logic        gt_flag;
    logic [4:0]  ss;
    logic [4:0]  se;
    logic [4:0]  mux;
    logic [15:0] thr;
    logic        start;
    logic        irq;
    logic        wake;
    logic [7:0]  rdata;
  } cst_top_state_t;

  // Whole state of the comparator and accumulator
  typedef struct packed {
    logic [3:0]  cnt;
    logic [19:0] sum;
    logic        fin;
    logic        gt;
  } cst_cmp_state_t;
endpackage : cst_pkg

// ---- inc/cst_cmp_if.sv ----
`timescale 1ns/1ps
interface cst_cmp_if;
  logic        conv_done;
  logic [15:0] result;
  logic [1:0]  acc_code;
  logic [15:0] thr;
  logic        clr;
  logic        final_pulse;
  logic        gt;
  modport top (output conv_done, result, acc_code, thr, clr, input final_pulse, gt);
  modport cmp (input conv_done, result, acc_code, thr, clr, output final_pulse, gt);
endinterface : cst_cmp_if

// ---- core/cst_compare.sv ----
`timescale 1ns/1ps
module cst_compare (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  cst_cmp_if.cmp   u_if
);
  import cst_pkg::*;

  cst_cmp_state_t s_q;
  cst_cmp_state_t s_d;
  logic [3:0]     last_idx;
  logic [2:0]     shift;
  logic [19:0]    total;
  logic [19:0]    avg;

  // Accumulate conversions; compare only once the set is complete
  always_comb begin
    s_d = s_q;
    s_d.fin = 1'b0;
    case (u_if.acc_code)
      2'h0: begin last_idx = 4'h0; shift = 3'h0; end
      2'h1: begin last_idx = 4'h3; shift = 3'h2; end
      2'h2: begin last_idx = 4'h7; shift = 3'h3; end
      default: begin last_idx = 4'hF; shift = 3'h4; end
    endcase
    total = s_q.sum + {4'h0, u_if.result};
    avg = total >> shift;
    if (u_if.clr) begin
      s_d.cnt = 4'h0;
      s_d.sum = 20'h00000;
    end else if (u_if.conv_done) begin
      if (s_q.cnt == last_idx) begin
        s_d.fin = 1'b1;
        s_d.gt = avg > {4'h0, u_if.thr};
        s_d.cnt = 4'h0;
        s_d.sum = 20'h00000;
      end else begin
        s_d.cnt = s_q.cnt + 4'h1;
        s_d.sum = total;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign u_if.final_pulse = s_q.fin;
  assign u_if.gt = s_q.gt;

  a_partial_no_final: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    (u_if.conv_done && !u_if.clr && s_q.cnt != last_idx) |=> !s_q.fin)
    else $error("comparison made before the last accumulated conversion");
endmodule : cst_compare

// ---- core/cst_top.sv ----
`timescale 1ns/1ps
`include "cst_defs.svh"
// Contract
// - Final result above threshold sets flag, else clears
// - Accumulated sets compare only after last conversion
// - Flag set with enable requests interrupt
// - Auto-scan halts on flag until busy written
// - Greater-than event wakes chip from suspend
// - Wake works without interrupt enable
// - Scan start holds five-bit first channel
// - Start write loads mux when auto-scan enabled, except in a final-result cycle
// - Scan end holds five-bit last channel
// - Range upper bits read zero; reset zero
// - Range registers at 0xDD, 0xDE page zero
// - Halt keeps causing channel; busy resumes there
// - Full scan without event stops, optional wake
// - Mux valid only with flag set, idle
module cst_top (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_b,
  input  wire logic [7:0]  i_sfr_page,
  input  wire logic [7:0]  i_sfr_addr,
  input  wire logic        i_sfr_wr,
  input  wire logic        i_sfr_rd,
  input  wire logic [7:0]  i_sfr_wdata,
  output      logic [7:0]  o_sfr_rdata,
  input  wire logic        i_compare_irq_enable,
  input  wire logic        i_conv_done,
  input  wire logic [15:0] i_conv_result,
  output      logic        o_conv_start,
  output      logic [4:0]  o_mux_channel,
  output      logic        o_busy,
  output      logic        o_mux_valid,
  output      logic        o_cmp_irq,
  output      logic        o_wake
);
  import cst_pkg::*;

  cst_top_state_t s_q;
  cst_top_state_t s_d;
  cst_cmp_if      u_cmp_if ();
  logic           on_page;
  logic           wr_cfg;
  logic           wr_ctl;
  logic           wr_ss;
  logic           wr_se;
  logic           autoscan;
  logic           go;
  logic           fin;
  logic           fin_gt;
  logic           at_end;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  assign on_page  = i_sfr_page == `CST_PAGE_MAIN;
  assign wr_cfg   = i_sfr_wr && on_page && i_sfr_addr == `CST_ADDR_CONFIG;
  assign wr_ctl   = i_sfr_wr && on_page && i_sfr_addr == `CST_ADDR_CONTROL;
  assign wr_ss    = i_sfr_wr && on_page && i_sfr_addr == `CST_ADDR_SCAN_START;
  assign wr_se    = i_sfr_wr && on_page && i_sfr_addr == `CST_ADDR_SCAN_END;
  assign autoscan = s_q.cfg[`CST_CFG_MODE_HI:`CST_CFG_MODE_LO] == `CST_MODE_TOUCH_STOP;
  // Busy write only starts from idle; a write during a scan cannot restart it
  assign go       = wr_ctl && i_sfr_wdata[`CST_CTL_BUSY] && i_sfr_wdata[`CST_CTL_ENABLE]
                    && s_q.st == CST_IDLE;
  assign fin      = s_q.st == CST_CONV && u_cmp_if.final_pulse;
  assign fin_gt   = fin && u_cmp_if.gt;
  assign at_end   = s_q.mux == s_q.se;

  ////////////////////////////////////////////////////////////////////////////
  // Comparator hookup
  assign u_cmp_if.conv_done = i_conv_done;
  assign u_cmp_if.result    = i_conv_result;
  assign u_cmp_if.acc_code  = s_q.cfg[`CST_CFG_ACC_HI:`CST_CFG_ACC_LO];
  assign u_cmp_if.thr       = s_q.thr;
  assign u_cmp_if.clr       = s_q.start;

  cst_compare u_compare (
    .i_clk_sys (i_clk_sys),
    .i_rst_b   (i_rst_b),
    .u_if      (u_cmp_if)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state: software writes first, hardware events after so they win
  always_comb begin
    s_d = s_q;
    s_d.start = 1'b0;
    s_d.irq = 1'b0;
    s_d.wake = 1'b0;
    if (wr_cfg) begin
      s_d.cfg = i_sfr_wdata & `CST_CFG_WMASK;
    end
    if (wr_ctl) begin
      s_d.en = i_sfr_wdata[`CST_CTL_ENABLE];
      s_d.int_flag = i_sfr_wdata[`CST_CTL_INT_FLAG];
      s_d.gt_flag = i_sfr_wdata[`CST_CTL_GT_FLAG];
    end
    if (wr_ss) begin
      s_d.ss = i_sfr_wdata[4:0];
      if (autoscan) begin
        s_d.mux = i_sfr_wdata[4:0];
      end
    end
    if (wr_se) begin
      s_d.se = i_sfr_wdata[4:0];
    end
    if (i_sfr_wr && on_page && i_sfr_addr == `CST_ADDR_THR_LOW) begin
      s_d.thr[7:0] = i_sfr_wdata;
    end
    if (i_sfr_wr && on_page && i_sfr_addr == `CST_ADDR_THR_HIGH) begin
      s_d.thr[15:8] = i_sfr_wdata;
    end
    if (i_sfr_wr && on_page && i_sfr_addr == `CST_ADDR_MUX_SEL && s_q.st == CST_IDLE) begin
      s_d.mux = i_sfr_wdata[4:0];
    end
    // Conversion sequencing; resume starts from whatever the mux holds
    case (s_q.st)
      CST_IDLE: begin
        if (go) begin
          s_d.st = CST_CONV;
          s_d.busy = 1'b1;
          s_d.start = 1'b1;
        end
      end
      CST_CONV: begin
        if (fin) begin
          s_d.gt_flag = u_cmp_if.gt;
          s_d.int_flag = 1'b1;
          if (u_cmp_if.gt) begin
            s_d.irq = i_compare_irq_enable;
            s_d.wake = 1'b1;
          end
          if (autoscan && !u_cmp_if.gt && !at_end) begin
            s_d.mux = s_q.mux + 5'h01;
            s_d.start = 1'b1;
          end else begin
            s_d.st = CST_IDLE;
            s_d.busy = 1'b0;
            // A start write landing now must not move the channel that tripped
            if (u_cmp_if.gt) begin
              s_d.mux = s_q.mux;
            end
            if (autoscan && !u_cmp_if.gt) begin
              s_d.mux = s_q.ss;
              s_d.wake = s_q.cfg[`CST_CFG_WAKE_END];
            end
          end
        end
      end
      default: begin
        s_d.st = CST_IDLE;
      end
    endcase
    // Registered read data; unmapped addresses read zero
    if (i_sfr_rd) begin
      s_d.rdata = `CST_RST_BYTE;
      if (on_page) begin
        case (i_sfr_addr)
          `CST_ADDR_CONFIG:     s_d.rdata = s_q.cfg;
          `CST_ADDR_CONTROL:    s_d.rdata = {s_q.en, 1'b0, s_q.int_flag, s_q.busy,
                                             3'h0, s_q.gt_flag};
          `CST_ADDR_SCAN_START: s_d.rdata = {3'h0, s_q.ss};
          `CST_ADDR_SCAN_END:   s_d.rdata = {3'h0, s_q.se};
          `CST_ADDR_THR_LOW:    s_d.rdata = s_q.thr[7:0];
          `CST_ADDR_THR_HIGH:   s_d.rdata = s_q.thr[15:8];
          `CST_ADDR_MUX_SEL:    s_d.rdata = {3'h0, s_q.mux};
          default:              s_d.rdata = `CST_RST_BYTE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_q <= '0;
      s_q.st <= CST_IDLE;
      s_q.ss <= `CST_RST_CHAN;
      s_q.se <= `CST_RST_CHAN;
      s_q.thr <= `CST_RST_THR;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign o_sfr_rdata   = s_q.rdata;
  assign o_conv_start  = s_q.start;
  assign o_mux_channel = s_q.mux;
  assign o_busy        = s_q.busy;
  assign o_cmp_irq     = s_q.irq;
  assign o_wake        = s_q.wake;
  // Mid-scan the mux is moving, so it only means something once halted
  assign o_mux_valid   = s_q.int_flag && !s_q.busy;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_gt_sets_flag: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    fin |=> s_q.gt_flag == $past(u_cmp_if.gt) && s_q.int_flag)
    else $error("greater-than flag does not follow the comparison");
  a_irq_gated_enable: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    o_cmp_irq |-> $past(fin_gt) && $past(i_compare_irq_enable))
    else $error("interrupt request without an enabled greater-than event");
  a_halt_on_gt: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    (fin_gt ##1 !go [*3]) |=> !s_q.busy && !o_conv_start)
    else $error("scan continued after a greater-than event");
  a_wake_on_gt: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    fin_gt |=> o_wake && o_mux_channel == $past(s_q.mux))
    else $error("greater-than event did not wake or lost its channel");
  a_start_loads_mux: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    (wr_ss && autoscan && !fin) |=> o_mux_channel == $past(i_sfr_wdata[4:0]))
    else $error("scan start write did not reach the mux");
  a_range_upper_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    (i_sfr_rd && on_page && (i_sfr_addr == `CST_ADDR_SCAN_START
      || i_sfr_addr == `CST_ADDR_SCAN_END)) |=> o_sfr_rdata[7:5] == 3'h0)
    else $error("scan range upper bits not zero");
  a_scan_end_stop: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    (fin && !u_cmp_if.gt && autoscan && at_end) |=>
      !s_q.busy && o_wake == $past(s_q.cfg[`CST_CFG_WAKE_END]))
    else $error("scan end did not stop or wake as configured");
  a_mux_steps_up: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    (fin && !u_cmp_if.gt && autoscan && !at_end) |=>
      o_mux_channel == $past(s_q.mux) + 5'h01 && o_conv_start)
    else $error("scan did not step to the next channel");
  a_start_has_cause: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    o_conv_start |-> $past(go) || $past(fin))
    else $error("conversion started without busy write or scan step");
endmodule : cst_top

// ---- dv/cst_top_tb.sv ----
`timescale 1ns/1ps
module cst_top_tb;
  import cst_pkg::*;
  `define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end

  logic        clk;
  logic        rst_b;
  logic [7:0]  pg;
  logic [7:0]  adr;
  logic [7:0]  wd;
  logic [7:0]  rv;
  logic        wr_s;
  logic        rd_s;
  logic        ien;
  logic        done;
  logic [15:0] res;
  logic [7:0]  rdat;
  logic        st;
  logic [4:0]  mux;
  logic        busy;
  logic        mv;
  logic        irq;
  logic        wake;
  logic [4:0]  st_ch;
  int          starts;
  int          seen;
  int          irqs;
  int          wakes;
  int          cyc;
  int          failures;
  int          num_checks;

  cst_top i_cst_top (
    .i_clk_sys            (clk),
    .i_rst_b              (rst_b),
    .i_sfr_page           (pg),
    .i_sfr_addr           (adr),
    .i_sfr_wr             (wr_s),
    .i_sfr_rd             (rd_s),
    .i_sfr_wdata          (wd),
    .o_sfr_rdata          (rdat),
    .i_compare_irq_enable (ien),
    .i_conv_done          (done),
    .i_conv_result        (res),
    .o_conv_start         (st),
    .o_mux_channel        (mux),
    .o_busy               (busy),
    .o_mux_valid          (mv),
    .o_cmp_irq            (irq),
    .o_wake               (wake)
  );

  ////////////////////////////////////////////////////////////////////////
  // Clock and pulse counters; pulses last one cycle so count them at the edge
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (st) begin
      starts++;
      st_ch = mux;
    end
    if (irq) irqs++;
    if (wake) wakes++;
    if (cyc == 5000) begin
      failures++;
      $display("[ERR] cycle limit exp %0d got %0d", 4999, cyc);
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus and converter tasks; strobes held across exactly one edge
  task automatic w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : w

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk); #1 wr_s = 1'b1; adr = a; wd = d;
    @(posedge clk); #1 wr_s = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk); #1 rd_s = 1'b1; adr = a;
    @(posedge clk); #1 rd_s = 1'b0;
    rv = rdat;
  endtask : rd

  // Converter must hand over n results per start; no extra dones when idle
  task automatic dn(input int n, input logic [15:0] r);
    repeat (n) begin
      @(posedge clk); #1 done = 1'b1; res = r;
      @(posedge clk); #1 done = 1'b0;
    end
  endtask : dn

  task automatic cv(input int n, input logic [15:0] r, input logic [4:0] ch);
    int k;
    k = 0;
    while (starts == seen && k < 100) begin
      w(1);
      k++;
    end
    if (k == 100) begin
      failures++;
      $display("[ERR] conversion start exp %0d got %0d", seen + 1, starts);
    end
    seen = starts;
    `CHK("start channel", ch, st_ch)
    dn(n, r);
    w(4);
  endtask : cv

  task automatic wrap_up;
    $display("Checks %0d, failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {pg, adr, wd, wr_s, rd_s, ien, done, res} = '0;
    {starts, seen, irqs, wakes, cyc, failures, num_checks} = '0;
    rst_b = 1'b0;
    w(5);
    rst_b = 1'b1;
    // Range registers: reset, upper bits, page decode
    rd(8'hDD); `CHK("start rst", 8'h00, rv)
    rd(8'hDE); `CHK("end rst", 8'h00, rv)
    wr(8'hDD, 8'hFF); rd(8'hDD); `CHK("start", 8'h1F, rv)
    wr(8'hDE, 8'hEA); rd(8'hDE); `CHK("end", 8'h0A, rv)
    pg = 8'h01;
    wr(8'hDD, 8'h05); rd(8'hDD); `CHK("page1 rd", 8'h00, rv)
    pg = 8'h00;
    rd(8'hDD); `CHK("page1 wr", 8'h1F, rv)
    // Single conversions around threshold 100, boundary included
    wr(8'hD9, 8'h64); wr(8'hDA, 8'h00); wr(8'hAA, 8'h00);
    wr(8'hB0, 8'h90); cv(1, 16'd100, 5'h00);
    rd(8'hB0); `CHK("gt equal", 1'b0, rv[0])
    wr(8'hB0, 8'h90); cv(1, 16'd101, 5'h00);
    rd(8'hB0); `CHK("gt above", 1'b1, rv[0])
    `CHK("irq masked", 0, irqs)
    `CHK("wake single", 1, wakes)
    w(10); rd(8'hB0); `CHK("gt held", 1'b1, rv[0])
    // Four accumulated: last raw alone is below, the average is above
    wr(8'hAA, 8'h01); wr(8'hB0, 8'h80); wr(8'hB0, 8'h90);
    cv(3, 16'd104, 5'h00);
    rd(8'hB0); `CHK("no early cmp", 1'b0, rv[5])
    dn(1, 16'd96); w(4);
    rd(8'hB0); `CHK("acc gt", 1'b1, rv[0])
    // Touch-stop auto-scan from 2 to 4, halting on channel 3
    ien = 1'b1;
    wr(8'hAA, 8'h58); wr(8'hDE, 8'h04); wr(8'hDD, 8'h02);
    `CHK("start to mux", 5'h02, mux)
    wr(8'hB0, 8'h80); wr(8'hB0, 8'h90);
    cv(1, 16'd50, 5'h02);
    cv(1, 16'd200, 5'h03);
    `CHK("halt busy", 1'b0, busy)
    `CHK("halt mux", 5'h03, mux)
    `CHK("mux valid", 1'b1, mv)
    `CHK("irq", 1, irqs)
    `CHK("wake gt", 3, wakes)
    w(20); `CHK("no restart", seen, starts)
    // Resume on the tripping channel, then finish without an event
    wr(8'hB0, 8'h90);
    cv(1, 16'd50, 5'h03);
    cv(1, 16'd50, 5'h04);
    `CHK("end busy", 1'b0, busy)
    `CHK("end mux", 5'h02, mux)
    `CHK("wake end", 4, wakes)
    // Wake without the interrupt enable
    ien = 1'b0;
    wr(8'hB0, 8'h90);
    cv(1, 16'd300, 5'h02);
    `CHK("wake no ien", 5, wakes)
    `CHK("irq no ien", 1, irqs)
    wrap_up();
  end
endmodule : cst_top_tb
